// ---- verilog/phy_led_aux_status_regs.sv ----
// Functional notes
// - link-10 lamp forced on by lamp control bit 15, suppressed by bit 14.
// - link-100 lamp forced on by bit 13, disabled by bit 12, else default.
// - link-1000 lamp forced on by bit 11, disabled by bit 10, else default.
// - activity lamp forced on by bit 7, disabled by bit 6, else activity.
// - bit 3 pulses every lit lamp at 5 kHz, 20 percent duty.
// - bit 2 makes the activity lamp blink during activity.
// - bit 1 selects 10 Hz blink, clear selects 5 Hz.
// - aux status bit 15 mirrors the auto-negotiation complete flag.
// - aux status bit 14 is the inverse of auto-negotiation enable.
// - aux status bit 13 shows internal crossover performed.
// - aux status bit 12 shows C and D pairs swapped.
// - aux status bits 11 to 8 show polarity reversal on pairs A to D.
// - aux status bits 4:3 give speed 00/01/10 for 10/100/1000.
// - retain bit set keeps sticky bits across software reset.
// - retain bit clear returns sticky bits to defaults on software reset.
// - super-sticky bits, retain bit included, survive any software reset.
// - skew register gives 3-bit symbol-time skew per pair A to D.
// - register 30 is reserved and reads as zero.
// - simple lamp controls apply only under the simple lamp method.
module phy_led_aux_status_regs
	import lamp_status_pkg::*;
#(
	parameter int BLINK_FAST_HALF = BLINK_FAST_HALF_CYC,
	parameter int BLINK_SLOW_HALF = BLINK_SLOW_HALF_CYC
)
(
	input  wire logic            mclk,
	input  wire logic            resetn,
	input  wire logic            mdc,
	input  wire logic            mdio_in,
	output logic                 mdio_out_q,
	output logic                 mdio_oe_n_q,
	input  wire logic [4:0]      phy_addr,
	input  wire logic            soft_reset,
	input  wire link_status_type link_status,
	input  wire logic            lamp_method_enhanced,
	input  wire logic [3:0]      enhanced_lamp,
	output logic                 lamp_out_link10,
	output logic                 lamp_out_link100,
	output logic                 lamp_out_link1000,
	output logic                 lamp_out_activity
);

	////////////////////////////////////////////////////////////////////////////////
	// management frame receiver and responder

	frame_state_type state_q;
	logic            mdc_prev_q;
	logic [5:0]      cnt_q;
	logic [15:0]     in_sh_q;
	logic [15:0]     rd_sh_q;
	logic [1:0]      op_q;
	logic            phy_hit_q;
	logic [4:0]      reg_q;
	logic            mdc_rise;
	logic            in_bank;
	logic            read_ours;
	logic            wr_fire;
	logic [15:0]     wr_data;
	logic [15:0]     rdata;
	logic [15:0]     lamp_ctrl_q;
	logic            retain_q;

	assign mdc_rise  = mdc & ~mdc_prev_q;
	assign in_bank   = (reg_q >= REG_LAMP_CTRL) && (reg_q <= REG_RESERVED_30);
	// foreign phys and addresses outside the bank leave the pin released
	assign read_ours = phy_hit_q && in_bank && (op_q == OP_READ);
	// last data bit is taken straight off the pin at the 16th rise
	assign wr_data   = {in_sh_q[14:0], mdio_in};
	assign wr_fire   = mdc_rise && (state_q == ST_WDATA) && (cnt_q == 6'h0F)
	                   && phy_hit_q && (op_q == OP_WRITE);

	// reset as if high: an mdc already high at release is no false first bit
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mdc_prev_q <= 1'b1;
		end else begin
			mdc_prev_q <= mdc;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			in_sh_q <= '0;
		end else if (mdc_rise) begin
			in_sh_q <= {in_sh_q[14:0], mdio_in};
		end
	end

	// frame sequencing; a frame needs a fresh preamble, so a stray bit only
	// costs the host one retry rather than a misaligned write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q   <= ST_PRE;
			cnt_q     <= '0;
			op_q      <= '0;
			phy_hit_q <= 1'b0;
			reg_q     <= '0;
		end else if (mdc_rise) begin
			unique case (state_q)
				ST_PRE: begin
					if (mdio_in) begin
						if (cnt_q < PREAMBLE_ONES) begin
							cnt_q <= cnt_q + 1'b1;
						end
					end else if (cnt_q == PREAMBLE_ONES) begin
						cnt_q   <= '0;
						state_q <= ST_START;
					end else begin
						cnt_q <= '0;
					end
				end
				ST_START: begin
					cnt_q   <= '0;
					state_q <= mdio_in ? ST_OP : ST_PRE;
				end
				ST_OP: begin
					if (cnt_q == 6'h01) begin
						op_q    <= {in_sh_q[0], mdio_in};
						cnt_q   <= '0;
						state_q <= ST_PHY;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_PHY: begin
					if (cnt_q == 6'h04) begin
						phy_hit_q <= ({in_sh_q[3:0], mdio_in} == phy_addr);
						cnt_q     <= '0;
						state_q   <= ST_REG;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_REG: begin
					if (cnt_q == 6'h04) begin
						reg_q   <= {in_sh_q[3:0], mdio_in};
						cnt_q   <= '0;
						state_q <= ST_TURN;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				// first turnaround bit only counted; the second picks read, write or skip
				ST_TURN: begin
					if (cnt_q == 6'h00) begin
						cnt_q <= 6'h01;
					end else if (read_ours) begin
						cnt_q   <= '0;
						state_q <= ST_RDATA;
					end else if (op_q == OP_WRITE) begin
						cnt_q   <= '0;
						state_q <= ST_WDATA;
					end else begin
						cnt_q   <= '0;
						state_q <= ST_PRE;
					end
				end
				ST_WDATA, ST_RDATA: begin
					if (cnt_q == 6'h0F) begin
						cnt_q   <= '0;
						state_q <= ST_PRE;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	// pin driven only for our own reads: zero in the second turnaround bit,
	// then data msb first, each bit changed just after a rising mdc edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mdio_out_q  <= 1'b1;
			mdio_oe_n_q <= 1'b1;
			rd_sh_q     <= '0;
		end else if (mdc_rise) begin
			if (state_q == ST_TURN && cnt_q == 6'h00 && read_ours) begin
				mdio_out_q  <= 1'b0;
				mdio_oe_n_q <= 1'b0;
			end else if (state_q == ST_TURN && cnt_q == 6'h01 && read_ours) begin
				mdio_out_q <= rdata[15];
				rd_sh_q    <= {rdata[14:0], 1'b0};
			end else if (state_q == ST_RDATA && cnt_q != 6'h0F) begin
				mdio_out_q <= rd_sh_q[15];
				rd_sh_q    <= {rd_sh_q[14:0], 1'b0};
			end else begin
				mdio_out_q  <= 1'b1;
				mdio_oe_n_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	// sticky lamp controls; a write in the reset cycle wins
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lamp_ctrl_q <= LAMP_CTRL_RESET;
		end else if (wr_fire && reg_q == REG_LAMP_CTRL) begin
			lamp_ctrl_q <= wr_data & LAMP_CTRL_WMASK;
		end else if (soft_reset && !retain_q) begin
			lamp_ctrl_q <= LAMP_CTRL_RESET;
		end // holds when retain set
	end

	// super-sticky: only the hard reset and a status-register write touch it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			retain_q <= RETAIN_RESET;
		end else if (wr_fire && reg_q == REG_AUX_STATUS) begin
			retain_q <= wr_data[BIT_RETAIN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; status is sampled live at the turnaround

	// reserved bits 7:6, 2 and 0 of the status word fall out of the zero default
	always_comb begin
		rdata = '0;
		unique case (reg_q)
			REG_LAMP_CTRL: begin
				rdata = lamp_ctrl_q;
			end
			REG_AUX_STATUS: begin
				rdata[BIT_AN_DONE]                  = link_status.an_complete;
				rdata[BIT_AN_OFF]                   = ~link_status.an_enable;
				rdata[BIT_XOVER]                    = link_status.crossover;
				rdata[BIT_CD_SWAP]                  = link_status.cd_swap;
				rdata[POS_POLARITY+3:POS_POLARITY]  = link_status.polarity;
				rdata[BIT_FULL_DUPLEX]              = link_status.full_duplex_flag;
				rdata[POS_SPEED+1:POS_SPEED]        = link_status.speed;
				rdata[BIT_RETAIN]                   = retain_q;
			end
			REG_PAIR_SKEW: begin
				rdata[POS_SKEW_A+2:POS_SKEW_A]      = link_status.skew_a;
				rdata[POS_SKEW_B+2:POS_SKEW_B]      = link_status.skew_b;
				rdata[POS_SKEW_C+2:POS_SKEW_C]      = link_status.skew_c;
				rdata[POS_SKEW_D+2:POS_SKEW_D]      = link_status.skew_d;
			end
			default: begin
				rdata = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// lamp timing

	logic             pulse_phase;
	logic             blink_phase;
	logic [CNT_W-1:0] blink_half;
	logic [CNT_W-1:0] blink_period;
	logic             act_default;
	logic             link10_on;
	logic             link100_on;
	logic             link1000_on;

	assign blink_half   = lamp_ctrl_q[BIT_BLINK_FAST] ? CNT_W'(BLINK_FAST_HALF)
	                                                  : CNT_W'(BLINK_SLOW_HALF);
	assign blink_period = {blink_half[CNT_W-2:0], 1'b0};

	// free running, so a lamp lit mid-period starts at any phase of the pulse
	phase_gen u_pulse (
		.mclk     (mclk),
		.resetn   (resetn),
		.period   (CNT_W'(PULSE_PERIOD_CYC)),
		.on_count (CNT_W'(PULSE_ON_CYC)),
		.phase_q  (pulse_phase)
	);

	// a rate change applies at once to the running period, so a runt half can occur
	phase_gen u_blink (
		.mclk     (mclk),
		.resetn   (resetn),
		.period   (blink_period),
		.on_count (blink_half),
		.phase_q  (blink_phase)
	);

	// blink replaces the steady activity indication
	assign act_default = link_status.activity & (~lamp_ctrl_q[BIT_BLINK_EN] | blink_phase);
	// reserved speed code lights no link lamp
	assign link10_on   = link_status.link_up && (link_status.speed == SPEED_10);
	assign link100_on  = link_status.link_up && (link_status.speed == SPEED_100);
	assign link1000_on = link_status.link_up && (link_status.speed == SPEED_1000);

	// each channel lets the enhanced method bypass every simple control
	lamp_channel u_lamp10 (
		.mclk        (mclk),
		.resetn      (resetn),
		.enhanced    (lamp_method_enhanced),
		.enhanced_on (enhanced_lamp[3]),
		.force_on    (lamp_ctrl_q[BIT_L10_FORCE]),
		.force_off   (lamp_ctrl_q[BIT_L10_OFF]),
		.default_on  (link10_on),
		.pulse_en    (lamp_ctrl_q[BIT_PULSE_EN]),
		.pulse_phase (pulse_phase),
		.lamp_q      (lamp_out_link10)
	);

	lamp_channel u_lamp100 (
		.mclk        (mclk),
		.resetn      (resetn),
		.enhanced    (lamp_method_enhanced),
		.enhanced_on (enhanced_lamp[2]),
		.force_on    (lamp_ctrl_q[BIT_L100_FORCE]),
		.force_off   (lamp_ctrl_q[BIT_L100_OFF]),
		.default_on  (link100_on),
		.pulse_en    (lamp_ctrl_q[BIT_PULSE_EN]),
		.pulse_phase (pulse_phase),
		.lamp_q      (lamp_out_link100)
	);

	lamp_channel u_lamp1000 (
		.mclk        (mclk),
		.resetn      (resetn),
		.enhanced    (lamp_method_enhanced),
		.enhanced_on (enhanced_lamp[1]),
		.force_on    (lamp_ctrl_q[BIT_L1000_FORCE]),
		.force_off   (lamp_ctrl_q[BIT_L1000_OFF]),
		.default_on  (link1000_on),
		.pulse_en    (lamp_ctrl_q[BIT_PULSE_EN]),
		.pulse_phase (pulse_phase),
		.lamp_q      (lamp_out_link1000)
	);

	lamp_channel u_lamp_act (
		.mclk        (mclk),
		.resetn      (resetn),
		.enhanced    (lamp_method_enhanced),
		.enhanced_on (enhanced_lamp[0]),
		.force_on    (lamp_ctrl_q[BIT_ACT_FORCE]),
		.force_off   (lamp_ctrl_q[BIT_ACT_OFF]),
		.default_on  (act_default),
		.pulse_en    (lamp_ctrl_q[BIT_PULSE_EN]),
		.pulse_phase (pulse_phase),
		.lamp_q      (lamp_out_activity)
	);

endmodule

// ---- verilog/lamp_status_pkg.sv ----
package lamp_status_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets on the management interface
	localparam logic [4:0]  REG_LAMP_CTRL       = 5'h1B;
	localparam logic [4:0]  REG_AUX_STATUS      = 5'h1C;
	localparam logic [4:0]  REG_PAIR_SKEW       = 5'h1D;
	localparam logic [4:0]  REG_RESERVED_30     = 5'h1E;

	// simple_lamp_control fields
	localparam int          BIT_L10_FORCE       = 15;
	localparam int          BIT_L10_OFF         = 14;
	localparam int          BIT_L100_FORCE      = 13;
	localparam int          BIT_L100_OFF        = 12;
	localparam int          BIT_L1000_FORCE     = 11;
	localparam int          BIT_L1000_OFF       = 10;
	localparam int          BIT_ACT_FORCE       = 7;
	localparam int          BIT_ACT_OFF         = 6;
	localparam int          BIT_PULSE_EN        = 3;
	localparam int          BIT_BLINK_EN        = 2;
	localparam int          BIT_BLINK_FAST      = 1;
	localparam logic [15:0] LAMP_CTRL_WMASK     = 16'hFCCE;
	localparam logic [15:0] LAMP_CTRL_RESET     = 16'h0000;

	// auxiliary_link_status fields
	localparam int          BIT_AN_DONE         = 15;
	localparam int          BIT_AN_OFF          = 14;
	localparam int          BIT_XOVER           = 13;
	localparam int          BIT_CD_SWAP         = 12;
	localparam int          POS_POLARITY        = 8;
	localparam int          BIT_FULL_DUPLEX     = 5;
	localparam int          POS_SPEED           = 3;
	localparam int          BIT_RETAIN          = 1;
	localparam logic        RETAIN_RESET        = 1'b1;

	// pair_skew_status fields
	localparam int          POS_SKEW_A          = 12;
	localparam int          POS_SKEW_B          = 8;
	localparam int          POS_SKEW_C          = 4;
	localparam int          POS_SKEW_D          = 0;

	localparam logic [1:0]  SPEED_10            = 2'h0;
	localparam logic [1:0]  SPEED_100           = 2'h1;
	localparam logic [1:0]  SPEED_1000          = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// management frame
	localparam logic [1:0]  OP_READ             = 2'h2;
	localparam logic [1:0]  OP_WRITE            = 2'h1;
	localparam logic [5:0]  PREAMBLE_ONES       = 6'h20;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_HZ              = 10_000_000;
	localparam int          PULSE_PERIOD_US     = 200;
	localparam int          PULSE_ON_US         = 40;
	localparam int          BLINK_FAST_HZ       = 10;
	localparam int          BLINK_SLOW_HZ       = 5;
	localparam int          PULSE_PERIOD_CYC    = PULSE_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int          PULSE_ON_CYC        = PULSE_ON_US * (CLK_HZ / 1_000_000);
	localparam int          BLINK_FAST_HALF_CYC = CLK_HZ / (2 * BLINK_FAST_HZ);
	localparam int          BLINK_SLOW_HALF_CYC = CLK_HZ / (2 * BLINK_SLOW_HZ);
	localparam int          CNT_W               = 21;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic       an_complete;
		logic       an_enable;
		logic       crossover;
		logic       cd_swap;
		logic [3:0] polarity;
		logic       full_duplex_flag;
		logic [1:0] speed;
		logic       link_up;
		logic       activity;
		logic [2:0] skew_a;
		logic [2:0] skew_b;
		logic [2:0] skew_c;
		logic [2:0] skew_d;
	} link_status_type;

	typedef enum logic [2:0] {
		ST_PRE, ST_START, ST_OP, ST_PHY, ST_REG, ST_TURN, ST_WDATA, ST_RDATA
	} frame_state_type;

endpackage

// ---- verilog/phase_gen.sv ----
module phase_gen
	import lamp_status_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic [CNT_W-1:0] period,
	input  wire logic [CNT_W-1:0] on_count,
	output logic                  phase_q
);

	logic [CNT_W-1:0] cnt_q;

	// free running; a new period applies at once, a count already at or past its end wraps next cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (cnt_q >= period - 1'b1) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= (cnt_q < on_count);
		end
	end

endmodule

// ---- verilog/lamp_channel.sv ----
module lamp_channel
	import lamp_status_pkg::*;
(
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic enhanced,
	input  wire logic enhanced_on,
	input  wire logic force_on,
	input  wire logic force_off,
	input  wire logic default_on,
	input  wire logic pulse_en,
	input  wire logic pulse_phase,
	output logic      lamp_q
);

	logic lit;

	always_comb begin
		if (force_off) begin
			lit = 1'b0;
		end else if (force_on) begin
			lit = 1'b1;
		end else begin
			lit = default_on;
		end
	end

	// enhanced method owns the pin outright; none of the simple controls reach it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lamp_q <= 1'b0;
		end else if (enhanced) begin
			lamp_q <= enhanced_on;
		end else begin
			lamp_q <= lit & (~pulse_en | pulse_phase);
		end
	end

endmodule

// ---- tb/lamp_checker_properties.sv ----
module lamp_checker_properties
	import lamp_status_pkg::*;
#(
	parameter int BLINK_FAST_HALF = BLINK_FAST_HALF_CYC,
	parameter int BLINK_SLOW_HALF = BLINK_SLOW_HALF_CYC
)
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       mdc,
	input wire logic       mdio_out_q,
	input wire logic       mdio_oe_n_q,
	input wire logic       lamp_method_enhanced,
	input wire logic [3:0] enhanced_lamp,
	input wire logic       lamp_out_link10,
	input wire logic       lamp_out_link100,
	input wire logic       lamp_out_link1000,
	input wire logic       lamp_out_activity
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	logic       mdc_prev_q;
	logic       mdc_rise;
	logic [4:0] rises_q;
	logic [3:0] lamps;

	assign mdc_rise = mdc & ~mdc_prev_q;
	assign lamps = {lamp_out_link10, lamp_out_link100, lamp_out_link1000, lamp_out_activity};

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			mdc_prev_q <= 1'b1;
		else
			mdc_prev_q <= mdc;
	end

	// rises seen while a read burst drives the line
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rises_q <= 5'h00;
		else if (mdio_oe_n_q)
			rises_q <= 5'h00;
		else if (mdc_rise)
			rises_q <= rises_q + 5'h01;
	end

	////////////////////////////////////////
	a_release_high: assert property (mdio_oe_n_q |-> mdio_out_q)
		else $error("line released but data not high");
	a_first_bit_zero: assert property ($fell(mdio_oe_n_q) |-> !mdio_out_q)
		else $error("turnaround bit not driven low");
	a_drive_on_rise: assert property ($fell(mdio_oe_n_q) |-> $past(mdc_rise))
		else $error("drive began without an mdc rise");
	a_release_on_rise: assert property ($rose(mdio_oe_n_q) |-> $past(mdc_rise))
		else $error("release without an mdc rise");
	a_burst_bits: assert property ($rose(mdio_oe_n_q) |-> rises_q == 5'h11)
		else $error("read burst not 17 bit times");
	a_bit_stands: assert property (!mdio_oe_n_q && !$past(mdio_oe_n_q) && !$past(mdc_rise) |-> $stable(mdio_out_q))
		else $error("read bit changed between mdc rises");
	a_burst_bound: assert property ($fell(mdio_oe_n_q) |-> !mdio_oe_n_q [*8] ##[1:1000] mdio_oe_n_q)
		else $error("read burst too short or never ends");
	a_enh_lamps: assert property (lamp_method_enhanced |=> lamps == $past(enhanced_lamp))
		else $error("enhanced lamps not passed through");
	a_reset_lamps: assert property ($rose(resetn) |-> lamps == 4'h0)
		else $error("lamps lit out of reset");

	c_read: cover property ($fell(mdio_oe_n_q));
	c_enh: cover property (lamp_method_enhanced && enhanced_lamp == 4'hF);
	c_blink: cover property (!lamp_method_enhanced && $rose(lamp_out_activity));
endmodule

bind phy_led_aux_status_regs lamp_checker_properties #(.BLINK_FAST_HALF(BLINK_FAST_HALF),
	.BLINK_SLOW_HALF(BLINK_SLOW_HALF)) chk_u (.mclk, .resetn, .mdc, .mdio_out_q, .mdio_oe_n_q,
	.lamp_method_enhanced, .enhanced_lamp, .lamp_out_link10, .lamp_out_link100,
	.lamp_out_link1000, .lamp_out_activity);

// ---- tb/mgmt_host.sv ----
module mgmt_host
	import lamp_status_pkg::*;
(
	input  wire logic mclk,
	input  wire logic mdio_out_q,
	input  wire logic mdio_oe_n_q,
	output logic      mdc,
	output logic      mdio_in
);
	timeunit 1ns;
	timeprecision 1ns;

	logic drv;

	// pulled-up line: a released host shows the idle high level
	assign mdio_in = mdio_oe_n_q ? drv : mdio_out_q;

	initial begin
		mdc = 1'b0;
		drv = 1'b1;
	end

	// two mclk low, two high; sampled late in the low half
	task automatic bit_io(input logic b, output logic s);
		@(posedge mclk);
		mdc <= 1'b0;
		drv <= b;
		repeat (2) @(posedge mclk);
		s = mdio_in;
		mdc <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
	                     input logic [15:0] wd, output logic [15:0] rd);
		logic        s;
		logic [31:0] w;
		// a read leaves turnaround and data released
		w = {2'b01, op, pa, ra, (op == OP_READ) ? 18'h3FFFF : {2'b10, wd}};
		repeat (32) bit_io(1'b1, s);
		for (int i = 31; i >= 0; i--) begin
			bit_io(w[i], s);
			if (i < 16)
				rd[i] = s;
		end
		drv <= 1'b1;
	endtask
endmodule

// ---- tb/phy_led_aux_status_regs_tb.sv ----
module phy_led_aux_status_regs_tb
	import lamp_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int FAST_HALF = 10;
	localparam int SLOW_HALF = 20;

	logic            mclk;
	logic            resetn;
	logic            mdc;
	logic            mdio_in;
	logic            mdio_out_q;
	logic            mdio_oe_n_q;
	logic [4:0]      phy_addr;
	logic            soft_reset;
	link_status_type ls;
	logic            lamp_method_enhanced;
	logic [3:0]      enhanced_lamp;
	logic [3:0]      lamps;
	logic [15:0]     r;
	int              miscompares;
	int              n_checks;
	int              seed;
	int              cyc;
	int              ctl_m;
	int              retain_m;
	int              n;

	phy_led_aux_status_regs #(.BLINK_FAST_HALF(FAST_HALF), .BLINK_SLOW_HALF(SLOW_HALF)) dut_u (
		.mclk, .resetn, .mdc, .mdio_in, .mdio_out_q, .mdio_oe_n_q, .phy_addr, .soft_reset,
		.link_status(ls), .lamp_method_enhanced, .enhanced_lamp,
		.lamp_out_link10(lamps[3]), .lamp_out_link100(lamps[2]),
		.lamp_out_link1000(lamps[1]), .lamp_out_activity(lamps[0]));

	mgmt_host host_u (.mclk, .mdio_out_q, .mdio_oe_n_q, .mdc, .mdio_in);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			summarize();
		end
	end

	////////////////////////////////////////
	task automatic summarize();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] v;
		host_u.frame(OP_READ, phy_addr, ra, 16'h0000, v);
		check(v, exp);
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		host_u.frame(OP_WRITE, phy_addr, ra, d, r);
		repeat (3) @(posedge mclk);
	endtask

	function automatic logic [15:0] aux_m();
		return {ls.an_complete, ~ls.an_enable, ls.crossover, ls.cd_swap, ls.polarity, 2'b00,
		        ls.full_duplex_flag, ls.speed, 1'b0, retain_m[0], 1'b0};
	endfunction

	function automatic logic [15:0] skew_m();
		return {1'b0, ls.skew_a, 1'b0, ls.skew_b, 1'b0, ls.skew_c, 1'b0, ls.skew_d};
	endfunction

	// disable is applied last so it wins over force
	function automatic logic [3:0] lamp_m();
		logic [3:0] e;
		int         fp[4] = '{7, 11, 13, 15};
		e = {ls.link_up && ls.speed == SPEED_10, ls.link_up && ls.speed == SPEED_100,
		     ls.link_up && ls.speed == SPEED_1000, ls.activity};
		for (int i = 0; i < 4; i++) begin
			if (ctl_m[fp[i]])
				e[i] = 1'b1;
			if (ctl_m[fp[i] - 1])
				e[i] = 1'b0;
		end
		return e;
	endfunction

	// speed code 11 is reserved, so never offered
	function automatic link_status_type rand_ls();
		logic [31:0]     v;
		link_status_type s;
		v = $random(seed);
		s = v[$bits(link_status_type)-1:0];
		if (s.speed == 2'h3)
			s.speed = SPEED_1000;
		return s;
	endfunction

	task automatic to_toggle(output int c);
		logic v;
		v = lamps[0];
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (lamps[0] === v && c < 5000);
	endtask

	////////////////////////////////////////
	initial begin
		seed = 32'h048D;
		resetn = 1'b0;
		soft_reset = 1'b0;
		phy_addr = 5'h05;
		ls = '0;
		lamp_method_enhanced = 1'b0;
		enhanced_lamp = 4'h0;
		ctl_m = 0;
		retain_m = 1;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		for (int k = 0; k < 4; k++) begin
			ls <= rand_ls();
			@(posedge mclk);
			rd(REG_LAMP_CTRL, 16'h0000);
			rd(REG_AUX_STATUS, aux_m());
			rd(REG_PAIR_SKEW, skew_m());
			rd(REG_RESERVED_30, 16'h0000);
		end
		host_u.frame(OP_READ, phy_addr ^ 5'h01, REG_LAMP_CTRL, 16'h0000, r);
		check(r, 16'hFFFF);
		wr(REG_LAMP_CTRL, 16'hFFFF);
		wr(REG_PAIR_SKEW, 16'hFFFF);
		wr(REG_RESERVED_30, 16'hFFFF);
		wr(REG_AUX_STATUS, 16'hFFFD);
		retain_m = 0;
		rd(REG_LAMP_CTRL, 16'hFCCE);
		host_u.frame(OP_WRITE, phy_addr ^ 5'h01, REG_LAMP_CTRL, 16'h0000, r);
		rd(REG_LAMP_CTRL, 16'hFCCE);
		rd(REG_PAIR_SKEW, skew_m());
		rd(REG_RESERVED_30, 16'h0000);
		rd(REG_AUX_STATUS, aux_m());
		for (int k = 0; k < 8; k++) begin
			ls <= rand_ls();
			ctl_m = $random(seed) & 32'h0000FCC0;
			wr(REG_LAMP_CTRL, ctl_m[15:0]);
			check({12'h000, lamps}, {12'h000, lamp_m()});
		end
		// two whole pulse periods, so the start phase does not matter
		ls <= '0;
		wr(REG_LAMP_CTRL, 16'h8008);
		n = 0;
		repeat (4000) begin
			@(posedge mclk);
			n += lamps[3];
		end
		check(16'(n), 16'h0320);
		ls.activity <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(REG_LAMP_CTRL, k ? 16'h0004 : 16'h0006);
			repeat (3) to_toggle(n);
			check(16'(n), 16'(k ? SLOW_HALF : FAST_HALF));
		end
		for (int k = 0; k < 2; k++) begin
			wr(REG_AUX_STATUS, k ? 16'h0002 : 16'h0000);
			retain_m = k;
			wr(REG_LAMP_CTRL, 16'h8000);
			soft_reset <= 1'b1;
			@(posedge mclk);
			soft_reset <= 1'b0;
			rd(REG_LAMP_CTRL, k ? 16'h8000 : 16'h0000);
			rd(REG_AUX_STATUS, aux_m());
		end
		lamp_method_enhanced <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			enhanced_lamp <= 4'($random(seed));
			repeat (2) @(posedge mclk);
			check({12'h000, lamps}, {12'h000, enhanced_lamp});
		end
		summarize();
	end
endmodule
